// [rtl/blr_defines.svh]
`ifndef BLR_DEFINES_SVH
`define BLR_DEFINES_SVH
`define BLR_RESP_OKAY   2'h0
`define BLR_RESP_EXOKAY 2'h1
`define BLR_RESP_SLVERR 2'h2
`define BLR_RESP_DECERR 2'h3
`define BLR_LANE_BITS   8
`define BLR_MEM_BASE    32'h0000_0000
`endif

// [rtl/blr_pkg.sv]
package blr_pkg;
  typedef logic [1:0] blr_resp_t;
  typedef enum logic [1:0] {
    BLR_IDLE = 2'b00,
    BLR_DATA = 2'b01,
    BLR_RESP = 2'b11
  } blr_state_t;
endpackage : blr_pkg

// [rtl/blr_bus_if.sv]
`timescale 1ns/1ns
interface blr_bus_if #(
  parameter int AW = 32,
  parameter int DW = 32
);
  // write address
  logic          awvalid;
  logic          awready;
  logic [AW-1:0] awaddr;
  logic [7:0]    awlen;
  logic [2:0]    awsize;
  logic          awlock;
  // write data
  logic          wvalid;
  logic          wready;
  logic [DW-1:0] wdata;
  logic [DW/8-1:0] wstrb;
  logic          wlast;
  // write response
  logic          bvalid;
  logic          bready;
  logic [1:0]    bresp;
  // read address
  logic          arvalid;
  logic          arready;
  logic [AW-1:0] araddr;
  logic [7:0]    arlen;
  logic [2:0]    arsize;
  logic          arlock;
  // read data
  logic          rvalid;
  logic          rready;
  logic [DW-1:0] rdata;
  logic [1:0]    rresp;
  logic          rlast;

  modport slave (input awvalid, awaddr, awlen, awsize, awlock, wvalid, wdata, wstrb, wlast, bready,
                 arvalid, araddr, arlen, arsize, arlock, rready,
                 output awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp, rlast);
  modport master (output awvalid, awaddr, awlen, awsize, awlock, wvalid, wdata, wstrb, wlast, bready,
                  arvalid, araddr, arlen, arsize, arlock, rready,
                  input awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp, rlast);
endinterface : blr_bus_if

// [rtl/blr_slave.sv]
`timescale 1ns/1ns
`include "blr_defines.svh"
module blr_slave
  import blr_pkg::*;
#(
  parameter int AW    = 32,
  parameter int DW    = 32,
  parameter int DEPTH = 16,
  parameter logic [AW-1:0] MEM_SPAN = 32'h0000_1000
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // bus
  blr_bus_if.slave  bus,
  // user side
  input  wire logic big_endian_view,
  input  wire logic store_enable,
  input  wire logic [$clog2(DEPTH)-1:0] peek_index,
  output logic [DW-1:0] peek_data,
  output logic          error_seen
);
  localparam int NB = DW / 8;
  localparam int IW = $clog2(DEPTH);
  localparam int SW = $clog2(NB);

  logic [DW-1:0] mem [DEPTH];
  blr_state_t    wstate;
  blr_state_t    rstate;
  logic [AW-1:0] waddr;
  logic [2:0]    wsize;
  blr_resp_t     wresp;
  logic [AW-1:0] raddr;
  logic [2:0]    rsize;
  logic [7:0]    rcount;
  logic          rdecode;
  logic          rexcl;
  logic          excl_valid;
  logic [AW-1:0] excl_addr;

  function automatic logic in_range(input logic [AW-1:0] a);
    return (a - AW'(`BLR_MEM_BASE)) < MEM_SPAN;
  endfunction : in_range

  function automatic logic [IW-1:0] word_index(input logic [AW-1:0] a);
    return a[SW +: IW];
  endfunction : word_index

  // address step to the next aligned beat; the unaligned start is simply masked away
  function automatic logic [AW-1:0] next_beat(input logic [AW-1:0] a, input logic [2:0] s);
    logic [AW-1:0] n;
    n = AW'(1) << s;
    return (a & ~(n - AW'(1))) + n;
  endfunction : next_beat

  function automatic logic [DW-1:0] swap_bytes(input logic [DW-1:0] d);
    logic [DW-1:0] r;
    r = '0;
    for (int i = 0; i < NB; i++) begin
      r[i*`BLR_LANE_BITS +: `BLR_LANE_BITS] = d[(NB-1-i)*`BLR_LANE_BITS +: `BLR_LANE_BITS];
    end
    return r;
  endfunction : swap_bytes

  // write channel
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wstate     <= BLR_IDLE;
      waddr      <= '0;
      wsize      <= '0;
      wresp      <= `BLR_RESP_OKAY;
    end else begin
      case (wstate)
        BLR_IDLE: begin
          if (bus.awvalid) begin
            waddr  <= bus.awaddr;
            wsize  <= bus.awsize;
            wstate <= BLR_DATA;
            if (!in_range(bus.awaddr)) begin
              wresp <= `BLR_RESP_DECERR;
            end else if (!store_enable || (bus.awsize > 3'(SW))) begin
              wresp <= `BLR_RESP_SLVERR;
            end else if (bus.awlock && excl_valid && excl_addr == bus.awaddr) begin
              wresp <= `BLR_RESP_EXOKAY;
            end else begin
              wresp <= `BLR_RESP_OKAY;
            end
          end
        end
        BLR_DATA: begin
          if (bus.wvalid) begin
            waddr <= next_beat(waddr, wsize);
            if (bus.wlast) begin
              wstate <= BLR_RESP;
            end
          end
        end
        BLR_RESP: begin
          if (bus.bready) begin
            wstate <= BLR_IDLE;
          end
        end
        default: wstate <= BLR_IDLE;
      endcase
    end
  end

  // storage: lanes map straight to memory bytes, strobe per lane
  always_ff @(posedge sys_clk) begin
    if (wstate == BLR_DATA && bus.wvalid && wresp[1] == 1'b0) begin
      for (int i = 0; i < NB; i++) begin
        if (bus.wstrb[i]) begin
          mem[word_index(waddr)][i*`BLR_LANE_BITS +: `BLR_LANE_BITS] <=
            bus.wdata[i*`BLR_LANE_BITS +: `BLR_LANE_BITS];
        end
      end
    end
  end

  // exclusive monitor: one tracked address, cleared when any write response is taken, whatever its address, unless a locked read arms it in that cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      excl_valid <= 1'b0;
      excl_addr  <= '0;
    end else if (rstate == BLR_IDLE && bus.arvalid && bus.arlock && in_range(bus.araddr)) begin
      excl_valid <= 1'b1;
      excl_addr  <= bus.araddr;
    end else if (wstate == BLR_RESP && bus.bready) begin
      excl_valid <= 1'b0;
    end
  end

  // read channel
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rstate  <= BLR_IDLE;
      raddr   <= '0;
      rsize   <= '0;
      rcount  <= '0;
      rdecode <= 1'b0;
      rexcl   <= 1'b0;
    end else begin
      case (rstate)
        BLR_IDLE: begin
          if (bus.arvalid) begin
            raddr   <= bus.araddr;
            rsize   <= bus.arsize;
            rcount  <= bus.arlen;
            rdecode <= !in_range(bus.araddr);
            rexcl   <= bus.arlock;
            rstate  <= BLR_DATA;
          end
        end
        BLR_DATA: begin
          if (bus.rready) begin
            raddr <= next_beat(raddr, rsize);
            rcount <= rcount - 8'h01;
            if (rcount == 8'h00) begin
              rstate <= BLR_IDLE;
            end
          end
        end
        default: rstate <= BLR_IDLE;
      endcase
    end
  end

  // outputs
  always_comb begin
    bus.awready = (wstate == BLR_IDLE);
    bus.wready  = (wstate == BLR_DATA);
    bus.bvalid  = (wstate == BLR_RESP);
    bus.bresp   = wresp;
    bus.arready = (rstate == BLR_IDLE);
    bus.rvalid  = (rstate == BLR_DATA);
    bus.rlast   = (rstate == BLR_DATA) && (rcount == 8'h00);
    bus.rdata   = rdecode ? '0 : mem[word_index(raddr)];
    // per-beat response: the beat that falls past the store reports its own error
    if (rdecode) begin
      bus.rresp = `BLR_RESP_DECERR;
    end else if (!in_range(raddr) || rsize > 3'(SW) || !store_enable) begin
      bus.rresp = `BLR_RESP_SLVERR;
    end else if (rexcl) begin
      bus.rresp = `BLR_RESP_EXOKAY;
    end else begin
      bus.rresp = `BLR_RESP_OKAY;
    end
  end

  // user peek: big-endian view swaps lanes, memory bytes stay put
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      peek_data  <= '0;
      error_seen <= 1'b0;
    end else begin
      peek_data <= big_endian_view ? swap_bytes(mem[peek_index]) : mem[peek_index];
      if ((bus.bvalid && bus.bresp[1]) || (bus.rvalid && bus.rresp[1])) begin
        error_seen <= 1'b1;
      end
    end
  end
endmodule : blr_slave

// [rtl/blr_master.sv]
`timescale 1ns/1ns
`include "blr_defines.svh"
module blr_master
  import blr_pkg::*;
#(
  parameter int AW = 32,
  parameter int DW = 32
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // bus
  blr_bus_if.master bus,
  // user command
  input  wire logic            cmd_valid,
  input  wire logic            cmd_write,
  input  wire logic            cmd_lock,
  input  wire logic [AW-1:0]   cmd_addr,
  input  wire logic [7:0]      cmd_len,
  input  wire logic [2:0]      cmd_size,
  input  wire logic [DW-1:0]   cmd_data,
  // user result
  output logic                 busy,
  output logic                 beat_valid,
  output logic [DW-1:0]        beat_data,
  output logic [1:0]           beat_resp
);
  localparam int NB = DW / 8;
  blr_state_t st;
  logic [7:0] cnt;
  logic       wr;
  // lock is held with the command so a later change of cmd_lock cannot leak into a running burst
  logic       lock;
  logic [NB-1:0] strb;
  logic [AW-1:0] addr;
  logic [2:0]    size;
  logic [DW-1:0] data;

  // first-beat strobes from the address low bits keep address and lanes consistent; later beats set all lanes
  function automatic logic [NB-1:0] lane_mask(input logic [AW-1:0] a, input logic [2:0] s);
    logic [NB-1:0] m;
    int lo;
    int hi;
    lo = int'(a) % NB;
    hi = ((int'(a) / (1 << s)) * (1 << s)) % NB + (1 << s) - 1;
    m = '0;
    for (int i = 0; i < NB; i++) begin
      if (i >= lo && i <= hi) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : lane_mask

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st <= BLR_IDLE;
      cnt <= '0;
      wr <= 1'b0;
      lock <= 1'b0;
      strb <= '0;
      addr <= '0;
      size <= '0;
      data <= '0;
      beat_valid <= 1'b0;
      beat_data <= '0;
      beat_resp <= `BLR_RESP_OKAY;
      busy <= 1'b0;
    end else begin
      beat_valid <= 1'b0;
      case (st)
        BLR_IDLE: begin
          if (cmd_valid) begin
            wr <= cmd_write;
            lock <= cmd_lock;
            addr <= cmd_addr;
            size <= cmd_size;
            cnt <= cmd_len;
            data <= cmd_data;
            strb <= lane_mask(cmd_addr, cmd_size);
            busy <= 1'b1;
            st <= BLR_DATA;
          end
        end
        BLR_DATA: begin
          if (wr && bus.awready) begin
            st <= BLR_RESP;
          end else if (!wr && bus.arready) begin
            st <= BLR_RESP;
          end
        end
        BLR_RESP: begin
          if (wr && bus.wready && bus.wvalid) begin
            cnt <= cnt - 8'h01;
            strb <= {NB{1'b1}};
          end
          if (!wr && bus.rvalid) begin
            beat_valid <= 1'b1;
            beat_data <= bus.rdata;
            beat_resp <= bus.rresp;
            if (bus.rlast) begin
              st <= BLR_IDLE;
              busy <= 1'b0;
            end
          end
          if (wr && bus.bvalid) begin
            beat_valid <= 1'b1;
            beat_resp <= bus.bresp;
            st <= BLR_IDLE;
            busy <= 1'b0;
          end
        end
        default: st <= BLR_IDLE;
      endcase
    end
  end

  logic wdone;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wdone <= 1'b0;
    end else if (st == BLR_IDLE) begin
      wdone <= 1'b0;
    end else if (bus.wvalid && bus.wready && bus.wlast) begin
      wdone <= 1'b1;
    end
  end

  always_comb begin
    bus.awvalid = (st == BLR_DATA) && wr;
    bus.awaddr  = addr;
    bus.awlen   = cnt;
    bus.awsize  = size;
    bus.awlock  = lock;
    bus.arvalid = (st == BLR_DATA) && !wr;
    bus.araddr  = addr;
    bus.arlen   = cnt;
    bus.arsize  = size;
    bus.arlock  = lock;
    bus.wvalid  = (st == BLR_RESP) && wr && !wdone;
    bus.wdata   = data;
    bus.wstrb   = strb;
    bus.wlast   = (cnt == 8'h00);
    bus.bready  = 1'b1;
    bus.rready  = 1'b1;
  end
endmodule : blr_master

// [verif/blr_bus_asserts.sv]
`timescale 1ns/1ns
module blr_bus_asserts #(
  parameter logic [31:0] SPAN = 32'h0000_1000
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst,
  // write side
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        wlast,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  // read side
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] araddr,
  input wire logic [7:0]  arlen,
  input wire logic        arlock,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [1:0]  rresp,
  input wire logic        rlast
);
  logic       rd_oor;
  logic       rd_lock;
  logic [7:0] rd_len;
  logic [7:0] rd_cnt;
  // burst context captured at address acceptance, beats counted after it
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_oor  <= 1'b0;
      rd_lock <= 1'b0;
      rd_len  <= 8'h00;
      rd_cnt  <= 8'h00;
    end else if (arvalid && arready) begin
      rd_oor  <= (araddr >= SPAN);
      rd_lock <= arlock;
      rd_len  <= arlen;
      rd_cnt  <= 8'h00;
    end else if (rvalid && rready) begin
      rd_cnt <= rd_cnt + 8'h01;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  AST_B_AFTER_WLAST: assert property (wvalid && wready && wlast |=> bvalid)
    else $error("write response missing after last beat");
  AST_B_ONLY_AFTER_WLAST: assert property ($rose(bvalid) |-> $past(wvalid && wready && wlast))
    else $error("write response without last beat");
  AST_B_HOLD: assert property ((bvalid |-> $stable(bresp)) and (bvalid && !bready |=> bvalid))
    else $error("write response dropped or changed");
  AST_W_DRAINED: assert property (bvalid |-> !(wvalid && wready))
    else $error("write data taken while response pending");
  AST_R_AFTER_AR: assert property (arvalid && arready |=> rvalid)
    else $error("read data late after address");
  AST_R_HOLD: assert property (rvalid && !(rready && rlast) |=> rvalid)
    else $error("read burst cut short");
  AST_R_BEATS: assert property (rvalid && rready && rlast |-> rd_cnt == rd_len)
    else $error("read beat count wrong");
  AST_R_DECERR: assert property (rvalid && rd_oor |-> rresp == 2'h3)
    else $error("undecoded read beat not decode error");
  AST_R_NO_EXOKAY: assert property (rvalid && !rd_lock |-> rresp != 2'h1)
    else $error("exclusive okay on normal read");
endmodule : blr_bus_asserts

// [verif/tb_bus_lane_and_response_logic.sv]
`timescale 1ns/1ns
module tb_bus_lane_and_response_logic;
  import blr_pkg::*;
  localparam logic [31:0] SPAN = 32'h0000_1000;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        big_endian_view = 1'b0;
  logic        store_enable = 1'b1;
  logic [3:0]  peek_index = 4'h0;
  logic [31:0] peek_data;
  logic        error_seen;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  logic        cmd_lock = 1'b0;
  logic [31:0] cmd_addr = 32'h0;
  logic [7:0]  cmd_len = 8'h0;
  logic [2:0]  cmd_size = 3'h2;
  logic [31:0] cmd_data = 32'h0;
  logic        busy;
  logic        beat_valid;
  logic [31:0] beat_data;
  blr_resp_t   beat_resp;
  int          mismatches = 0;
  int          tests_run = 0;
  blr_bus_if u_blr_bus_if ();
  blr_slave #(.DEPTH(16), .MEM_SPAN(SPAN)) u_blr_slave (.sys_clk(sys_clk), .rst(rst), .bus(u_blr_bus_if.slave),
    .big_endian_view(big_endian_view), .store_enable(store_enable), .peek_index(peek_index),
    .peek_data(peek_data), .error_seen(error_seen));
  blr_master u_blr_master (.sys_clk(sys_clk), .rst(rst), .bus(u_blr_bus_if.master), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_lock(cmd_lock), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .cmd_size(cmd_size),
    .cmd_data(cmd_data), .busy(busy), .beat_valid(beat_valid), .beat_data(beat_data), .beat_resp(beat_resp));
  blr_bus_asserts #(.SPAN(SPAN)) u_blr_bus_asserts (.sys_clk(sys_clk), .rst(rst),
    .wvalid(u_blr_bus_if.wvalid), .wready(u_blr_bus_if.wready), .wlast(u_blr_bus_if.wlast),
    .bvalid(u_blr_bus_if.bvalid), .bready(u_blr_bus_if.bready), .bresp(u_blr_bus_if.bresp),
    .arvalid(u_blr_bus_if.arvalid), .arready(u_blr_bus_if.arready), .araddr(u_blr_bus_if.araddr),
    .arlen(u_blr_bus_if.arlen), .arlock(u_blr_bus_if.arlock), .rvalid(u_blr_bus_if.rvalid),
    .rready(u_blr_bus_if.rready), .rresp(u_blr_bus_if.rresp), .rlast(u_blr_bus_if.rlast));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  task automatic chk_resp(input string what, input blr_resp_t exp, input blr_resp_t got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_resp

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk_word

  // one command; every beat is judged, then the beat count
  task automatic run(input logic w, input logic lk, input logic [31:0] a, input logic [7:0] n,
                     input logic [2:0] sz, input logic [31:0] d, input blr_resp_t er, input logic [31:0] ed);
    int beats;
    int t;
    beats = 0;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_lock = lk;
    cmd_addr = a;
    cmd_len = n;
    cmd_size = sz;
    cmd_data = d;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    for (t = 0; t < 200 && (beats < (w ? 1 : n + 1) || busy !== 1'b0); t++) begin
      if (beat_valid === 1'b1) begin
        beats++;
        chk_resp("beat_resp", er, beat_resp);
        if (!w && er != 2'h2) chk_word("beat_data", ed, beat_data);
      end
      @(posedge sys_clk);
      #1;
    end
    chk_word("beat_count", w ? 32'h1 : 32'(n) + 32'h1, 32'(beats));
  endtask : run

  task automatic peek(input logic [3:0] i, input logic be, input logic [31:0] exp);
    @(posedge sys_clk);
    #1;
    peek_index = i;
    big_endian_view = be;
    @(posedge sys_clk);
    #1;
    chk_word("peek_data", exp, peek_data);
  endtask : peek

  task automatic t_endian();
    run(1, 0, 32'h8, 8'h0, 3'h2, 32'h0A0B0C0D, 2'h0, 32'h0);
    run(0, 0, 32'h8, 8'h0, 3'h2, 32'h0, 2'h0, 32'h0A0B0C0D);
    peek(4'h2, 1'b0, 32'h0A0B0C0D);
    peek(4'h2, 1'b1, 32'h0D0C0B0A);
    chk_word("error_seen", 32'h0, 32'(error_seen));
    $display("test endian done");
  endtask : t_endian

  task automatic t_unaligned();
    run(1, 0, 32'h10, 8'h0, 3'h2, 32'h0, 2'h0, 32'h0);
    run(1, 0, 32'h11, 8'h0, 3'h2, 32'h11223344, 2'h0, 32'h0);
    run(0, 0, 32'h10, 8'h0, 3'h2, 32'h0, 2'h0, 32'h11223300);
    $display("test unaligned done");
  endtask : t_unaligned

  task automatic t_excl();
    run(0, 1, 32'h8, 8'h0, 3'h2, 32'h0, 2'h1, 32'h0A0B0C0D);
    run(1, 1, 32'h8, 8'h0, 3'h2, 32'h0A0B0C0D, 2'h1, 32'h0);
    run(1, 1, 32'h4, 8'h0, 3'h2, 32'h5, 2'h0, 32'h0);
    run(0, 0, 32'h8, 8'h0, 3'h2, 32'h0, 2'h0, 32'h0A0B0C0D);
    $display("test exclusive done");
  endtask : t_excl

  // a burst that runs off the end of the store: first beat fine, second beat errors
  task automatic t_mixed();
    int beats;
    int t;
    beats = 0;
    run(1, 0, SPAN - 32'h4, 8'h0, 3'h2, 32'h55AA6699, 2'h0, 32'h0);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = 1'b0;
    cmd_lock = 1'b0;
    cmd_addr = SPAN - 32'h4;
    cmd_len = 8'h1;
    cmd_size = 3'h2;
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
    for (t = 0; t < 200 && beats < 2; t++) begin
      if (beat_valid === 1'b1) begin
        if (beats == 0) begin
          chk_resp("first_beat_resp", 2'h0, beat_resp);
          chk_word("first_beat_data", 32'h55AA6699, beat_data);
        end else begin
          chk_resp("second_beat_resp", 2'h2, beat_resp);
        end
        beats++;
      end
      @(posedge sys_clk);
      #1;
    end
    chk_word("mixed_beat_count", 32'h2, 32'(beats));
    $display("test mixed responses done");
  endtask : t_mixed

  task automatic t_errors();
    store_enable = 1'b0;
    run(1, 0, 32'h8, 8'h0, 3'h2, 32'h1, 2'h2, 32'h0);
    run(0, 0, 32'h8, 8'h1, 3'h2, 32'h0, 2'h2, 32'h0);
    store_enable = 1'b1;
    run(0, 0, 32'h8, 8'h0, 3'h3, 32'h0, 2'h2, 32'h0);
    run(0, 0, 32'h2000, 8'h3, 3'h2, 32'h0, 2'h3, 32'h0);
    run(1, 0, 32'h2000, 8'h2, 3'h2, 32'h7, 2'h3, 32'h0);
    chk_word("error_seen", 32'h1, 32'(error_seen));
    $display("test errors done");
  endtask : t_errors

  initial begin
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    t_endian();
    t_unaligned();
    t_excl();
    t_mixed();
    t_errors();
    conclude();
  end

  // the whole sequence needs about a hundred cycles
  initial begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
endmodule : tb_bus_lane_and_response_logic
